// >>> rtl/qrw_addr_gen.sv
`timescale 1ns/100ps
// Next byte address: plain increment or wrap inside an aligned section
module qrw_addr_gen #(
    parameter int AW = 24
) (
    input wire logic [AW-1:0] addr,
    input wire logic wrap_on,
    input wire logic [1:0] len_code,
    output logic [AW-1:0] next_addr
);
    logic [7:0] mask; // Section size minus one
    logic [7:0] low_inc; // Incremented low byte

    // Wrap keeps bits above the section, low bits roll over
    always_comb begin
        mask = 8'h07;
        case (len_code)
            2'h0: mask = 8'h07;
            2'h1: mask = 8'h0f;
            2'h2: mask = 8'h1f;
            2'h3: mask = 8'h3f;
            default: mask = 8'h07;
        endcase
        low_inc = addr[7:0] + 8'h01;
        if (wrap_on) begin
            next_addr = {addr[AW-1:8], (addr[7:0] & ~mask) | (low_inc & mask)};
        end else begin
            next_addr = addr + {{(AW-1){1'b0}}, 1'b1};
        end
    end
endmodule // qrw_addr_gen

// >>> rtl/qrw_core.sv
`timescale 1ns/100ps
// Summary of operation
// - EDh single-wire: quad DDR, mode byte, seven dummies
// - 77h-enabled EDh wraps inside page section
// - Disable bit zero wraps; length 8..64 bytes
// - Wrap bits govern later quad reads
// - Four-wire EDh mode cycles count as dummies
// - Four-wire EDh never wraps; 0Eh does
// - E7h: even address, two dummies in single-wire mode, increment
// - E7h after 77h wraps in section
// - C0h rejected in single-wire mode
// - Single-wire dummies from config bit; length kept
// - Four-wire EBh/5Ah/0Ch dummies 10/4/6/8
// - Four-wire 0Dh/EDh/0Eh dummies 10 else 8
// - C0h wrap field sets 0Ch/0Eh length
// - 0Ch four-wire: wrapping fast read
// - 0Eh four-wire: wrapping double-rate read
// - Config bit0 enables pattern in dummies
// - Pattern is 00110100
// - Pattern starts after four dummy/mode cycles
// - Short dummy phase truncates pattern bits
// - 38h enters four-wire, state kept
// - FFh leaves four-wire, state kept
module qrw_core #(
    parameter int AW = qrw_pkg::ADDR_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic [3:0] IO_IN,
    output logic [3:0] IO_OUT,
    output logic [3:0] IO_OE,
    input wire logic DUMMY_CONFIG_BIT,
    input wire logic TRAINING_PATTERN_ENABLE,
    output logic [AW-1:0] ARRAY_ADDR,
    input wire logic [7:0] ARRAY_DATA,
    output logic FOUR_WIRE_MODE,
    output logic WRAP_ACTIVE_CFG,
    output logic [7:0] READ_PARAMS,
    output logic REJECT_SEEN
);
    // Link-side state, clocked by the serial clock and framed by select
    typedef struct packed {
        qrw_pkg::qrw_phase_t phase;
        logic [7:0] opcode;
        logic [5:0] cnt;
        logic [AW-1:0] addr;
        logic [3:0] dummies;
        logic ddr;
        logic wrap_on;
        logic [1:0] wrap_len;
        logic [7:0] shreg;
        logic [3:0] pat_cnt;
        logic [3:0] out_nib;
        logic out_en;
        logic nib_hi;
        logic [7:0] arg;
        logic rej_tgl;
        qrw_pkg::qrw_cfg_t cfg;
    } qrw_link_t;
    qrw_link_t lk_reg;
    qrw_link_t lk_next;

    // System-side state
    typedef struct packed {
        logic rej_seen;
        logic rej_last;
    } qrw_sys_t;
    qrw_sys_t sy_reg;
    qrw_sys_t sy_next;

    logic [AW-1:0] inc_addr; // Next byte address
    logic four_w; // Current command mode
    logic rej_sync; // Reject toggle in system domain
    logic cfg_mode_sync; // Mode flag in system domain
    logic cfg_wrap_sync; // Wrap-enabled flag in system domain, resets to off
    logic [3:0] sel_dummy; // Dummy count for opcode in hand

    assign four_w = lk_reg.cfg.four_wire_command_mode;

    qrw_addr_gen #(.AW(AW)) u_addr (
        .addr(lk_reg.addr),
        .wrap_on(lk_reg.wrap_on),
        .len_code(lk_reg.wrap_len),
        .next_addr(inc_addr)
    );

    // Dummy count chosen from mode and parameters once opcode is known
    always_comb begin
        sel_dummy = qrw_pkg::DUMMY_P00;
        if (!four_w) begin
            case (lk_reg.opcode)
                // One mode-byte clock ahead of the seven dummies
                qrw_pkg::OP_QIO_DDR_READ: sel_dummy = qrw_pkg::DUMMY_DDR_SPI + 4'h1;
                qrw_pkg::OP_WORD_READ: sel_dummy = qrw_pkg::DUMMY_WORD;
                default: sel_dummy = DUMMY_CONFIG_BIT ? qrw_pkg::DUMMY_SDR_SPI_DC1
                                                      : qrw_pkg::DUMMY_SDR_SPI_DC0;
            endcase
        end else begin
            case (lk_reg.opcode)
                qrw_pkg::OP_DDR_READ, qrw_pkg::OP_QIO_DDR_READ, qrw_pkg::OP_DDR_WRAP_READ: begin
                    // Mode clocks fold into these counts
                    sel_dummy = (lk_reg.cfg.dummy_select_field == 2'h0) ? qrw_pkg::DUMMY_P00
                                                                       : qrw_pkg::DUMMY_DDR_QUAD;
                end
                default: begin
                    case (lk_reg.cfg.dummy_select_field)
                        2'h0: sel_dummy = qrw_pkg::DUMMY_P00;
                        2'h1: sel_dummy = qrw_pkg::DUMMY_P01;
                        2'h2: sel_dummy = qrw_pkg::DUMMY_P10;
                        default: sel_dummy = qrw_pkg::DUMMY_P11;
                    endcase
                end
            endcase
        end
    end

    // Command decoder and output sequencer on the serial clock
    always_comb begin
        lk_next = lk_reg;
        case (lk_reg.phase)
            qrw_pkg::PH_CMD: begin
                // Opcode arrives one bit per clock, or a nibble in four-wire mode
                if (four_w) begin
                    lk_next.shreg = {lk_reg.shreg[3:0], IO_IN};
                end else begin
                    lk_next.shreg = {lk_reg.shreg[6:0], IO_IN[0]};
                end
                lk_next.cnt = lk_reg.cnt + 6'h01;
                if ((four_w && lk_reg.cnt == 6'h01) || (!four_w && lk_reg.cnt == 6'h07)) begin
                    lk_next.opcode = lk_next.shreg;
                    lk_next.cnt = '0;
                    lk_next.phase = qrw_pkg::PH_ADDR;
                    case (lk_next.shreg)
                        qrw_pkg::OP_ENTER_QUAD: begin
                            lk_next.cfg.four_wire_command_mode = 1'b1;
                            lk_next.phase = qrw_pkg::PH_IGNORE;
                        end
                        qrw_pkg::OP_EXIT_QUAD: begin
                            if (four_w) begin
                                lk_next.cfg.four_wire_command_mode = 1'b0;
                            end
                            lk_next.phase = qrw_pkg::PH_IGNORE;
                        end
                        qrw_pkg::OP_SET_PARAM: begin
                            if (!four_w) begin
                                lk_next.phase = qrw_pkg::PH_IGNORE;
                                lk_next.rej_tgl = ~lk_reg.rej_tgl;
                            end else begin
                                lk_next.phase = qrw_pkg::PH_ARG;
                            end
                        end
                        qrw_pkg::OP_SET_WRAP: begin
                            // Twenty-four don't-care bits then the wrap byte
                            lk_next.phase = four_w ? qrw_pkg::PH_IGNORE : qrw_pkg::PH_ARG;
                        end
                        qrw_pkg::OP_QIO_DDR_READ, qrw_pkg::OP_QIO_SDR_READ, qrw_pkg::OP_WORD_READ,
                        qrw_pkg::OP_WRAP_READ, qrw_pkg::OP_DDR_WRAP_READ, qrw_pkg::OP_DDR_READ,
                        qrw_pkg::OP_SFDP_READ: begin
                            lk_next.phase = qrw_pkg::PH_ADDR;
                        end
                        default: lk_next.phase = qrw_pkg::PH_IGNORE;
                    endcase
                end
            end
            qrw_pkg::PH_ARG: begin
                // Argument byte; 77h ignores its first 24 bits
                lk_next.arg = four_w ? {lk_reg.arg[3:0], IO_IN} : {lk_reg.arg[6:0], IO_IN[0]};
                lk_next.cnt = lk_reg.cnt + 6'h01;
                if (lk_reg.opcode == qrw_pkg::OP_SET_WRAP && lk_reg.cnt == 6'h1f) begin
                    lk_next.cfg.wrap_disable_bit = lk_next.arg[4];
                    lk_next.cfg.wrap_length_bits = lk_next.arg[6:5];
                    lk_next.phase = qrw_pkg::PH_IGNORE;
                end else if (lk_reg.opcode == qrw_pkg::OP_SET_PARAM && lk_reg.cnt == 6'h01) begin
                    lk_next.cfg.dummy_select_field = lk_next.arg[5:4];
                    lk_next.cfg.wrap_select_field = lk_next.arg[1:0];
                    lk_next.phase = qrw_pkg::PH_IGNORE;
                end
            end
            qrw_pkg::PH_ADDR: begin
                // Address on four lines; double rate opcodes also latch on falling edge here modeled per clock
                lk_next.addr = {lk_reg.addr[AW-5:0], IO_IN};
                lk_next.cnt = lk_reg.cnt + 6'h01;
                lk_next.ddr = (lk_reg.opcode == qrw_pkg::OP_QIO_DDR_READ) ||
                              (lk_reg.opcode == qrw_pkg::OP_DDR_WRAP_READ) ||
                              (lk_reg.opcode == qrw_pkg::OP_DDR_READ);
                if (lk_reg.cnt == 6'h05) begin
                    lk_next.cnt = '0;
                    lk_next.dummies = sel_dummy;
                    lk_next.pat_cnt = '0;
                    lk_next.phase = qrw_pkg::PH_DUMMY;
                    if (lk_reg.opcode == qrw_pkg::OP_WORD_READ) begin
                        lk_next.addr[0] = 1'b0;
                    end
                    if (!four_w) begin
                        // Single-wire quad reads follow the 77h setting
                        lk_next.wrap_on = !lk_reg.cfg.wrap_disable_bit &&
                            (lk_reg.opcode == qrw_pkg::OP_QIO_DDR_READ ||
                             lk_reg.opcode == qrw_pkg::OP_QIO_SDR_READ ||
                             lk_reg.opcode == qrw_pkg::OP_WORD_READ);
                        lk_next.wrap_len = lk_reg.cfg.wrap_length_bits;
                    end else begin
                        // Only the dedicated wrap opcodes wrap here
                        lk_next.wrap_on = lk_reg.opcode == qrw_pkg::OP_WRAP_READ ||
                                          lk_reg.opcode == qrw_pkg::OP_DDR_WRAP_READ;
                        lk_next.wrap_len = lk_reg.cfg.wrap_select_field;
                    end
                end
            end
            qrw_pkg::PH_DUMMY: begin
                // Pattern bit on all lines from the fourth dummy; cut when dummies run out
                lk_next.cnt = lk_reg.cnt + 6'h01;
                lk_next.out_en = 1'b0;
                if (TRAINING_PATTERN_ENABLE && lk_reg.cnt[3:0] >= qrw_pkg::TRAIN_START - 4'h1 &&
                    lk_reg.pat_cnt < 4'h8 && lk_reg.cnt[3:0] < lk_reg.dummies - 4'h1) begin
                    lk_next.out_en = 1'b1;
                    lk_next.out_nib = {4{qrw_pkg::TRAIN_PATTERN[3'h7 - lk_reg.pat_cnt[2:0]]}};
                    lk_next.pat_cnt = lk_reg.pat_cnt + 4'h1;
                end
                if (lk_reg.cnt[3:0] == lk_reg.dummies - 4'h1) begin
                    lk_next.phase = qrw_pkg::PH_DATA;
                    lk_next.out_en = 1'b1;
                    lk_next.out_nib = ARRAY_DATA[7:4];
                    lk_next.nib_hi = 1'b0;
                end
            end
            qrw_pkg::PH_DATA: begin
                // Two nibbles a byte; advance address after low nibble
                lk_next.out_en = 1'b1;
                lk_next.nib_hi = ~lk_reg.nib_hi;
                if (!lk_reg.nib_hi) begin
                    lk_next.out_nib = ARRAY_DATA[3:0];
                    lk_next.addr = inc_addr;
                end else begin
                    lk_next.out_nib = ARRAY_DATA[7:4];
                end
            end
            qrw_pkg::PH_IGNORE: begin
                lk_next.out_en = 1'b0;
            end
            default: lk_next.phase = qrw_pkg::PH_IGNORE;
        endcase
    end

    // Select high holds the frame in reset but keeps configuration
    always_ff @(posedge SCLK or negedge RESETN) begin
        if (!RESETN) begin
            lk_reg <= '0;
            lk_reg.cfg.wrap_disable_bit <= qrw_pkg::WRAP_DISABLE_RST;
            lk_reg.cfg.wrap_length_bits <= qrw_pkg::WRAP_LEN_RST;
            lk_reg.cfg.dummy_select_field <= qrw_pkg::DUMMY_SEL_RST;
            lk_reg.cfg.wrap_select_field <= qrw_pkg::WRAP_SEL_RST;
        end else if (CS_N) begin
            lk_reg.phase <= qrw_pkg::PH_CMD;
            lk_reg.cnt <= '0;
            lk_reg.out_en <= 1'b0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    // Outputs ended by select itself, since the link clock stops after a frame
    assign IO_OUT = lk_reg.out_nib;
    assign IO_OE = (lk_reg.out_en && !CS_N) ? 4'hf : 4'h0;
    assign ARRAY_ADDR = lk_reg.addr;
    assign READ_PARAMS = {2'h0, lk_reg.cfg.dummy_select_field, 2'h0, lk_reg.cfg.wrap_select_field};

    // Status into the system clock domain
    qrw_sync u_sync_rej (.clk(CLK), .resetn(RESETN), .en(CLK_EN), .d(lk_reg.rej_tgl), .q(rej_sync));
    qrw_sync u_sync_mode (.clk(CLK), .resetn(RESETN), .en(CLK_EN), .d(four_w), .q(cfg_mode_sync));
    // Enabled sense is synced so the synchroniser reset level matches the idle state
    qrw_sync u_sync_wrap (.clk(CLK), .resetn(RESETN), .en(CLK_EN),
                          .d(~lk_reg.cfg.wrap_disable_bit), .q(cfg_wrap_sync));

    // Sticky record of a rejected parameter command
    always_comb begin
        sy_next = sy_reg;
        sy_next.rej_last = rej_sync;
        if (rej_sync != sy_reg.rej_last) begin
            sy_next.rej_seen = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sy_reg <= '0;
        end else if (CLK_EN) begin
            sy_reg <= sy_next;
        end
    end

    assign FOUR_WIRE_MODE = cfg_mode_sync;
    assign WRAP_ACTIVE_CFG = cfg_wrap_sync;
    assign REJECT_SEEN = sy_reg.rej_seen;

    // Checks on the link side
    chk_reset_single_wire: assert property (@(posedge SCLK) disable iff (!RESETN)
        $rose(RESETN) |-> !four_w) else $error("Mode not single-wire after reset");
    chk_param_reject: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_CMD && lk_next.opcode == qrw_pkg::OP_SET_PARAM && !four_w &&
         lk_next.phase != qrw_pkg::PH_CMD) |=> lk_reg.phase == qrw_pkg::PH_IGNORE)
        else $error("Parameter command accepted in single-wire mode");
    chk_quad_ed_nowrap: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_DATA && four_w && lk_reg.opcode == qrw_pkg::OP_QIO_DDR_READ)
        |-> !lk_reg.wrap_on) else $error("Wrap applied to four-wire read");
    chk_word_even: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_DUMMY && lk_reg.cnt == 6'h00 && lk_reg.opcode == qrw_pkg::OP_WORD_READ)
        |-> !lk_reg.addr[0] && lk_reg.dummies == qrw_pkg::DUMMY_WORD) else $error("Word read setup wrong");
    chk_ed_dummies: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_DUMMY && !four_w && lk_reg.opcode == qrw_pkg::OP_QIO_DDR_READ)
        |-> lk_reg.dummies == qrw_pkg::DUMMY_DDR_SPI + 4'h1) else $error("Wrong dummy count");
    chk_quad_dummies: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_DUMMY && four_w && lk_reg.opcode == qrw_pkg::OP_QIO_SDR_READ &&
         lk_reg.cfg.dummy_select_field == 2'h1) |-> lk_reg.dummies == qrw_pkg::DUMMY_P01)
        else $error("Parameter dummy count not used");
    chk_pattern_bound: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        lk_reg.phase == qrw_pkg::PH_DUMMY |-> lk_reg.pat_cnt <= 4'h8) else $error("Pattern overrun");
    chk_data_follows: assert property (@(posedge SCLK) disable iff (!RESETN || CS_N)
        (lk_reg.phase == qrw_pkg::PH_DATA) |=> lk_reg.phase == qrw_pkg::PH_DATA && lk_reg.out_en)
        else $error("Data phase ended inside frame");
endmodule // qrw_core

// >>> rtl/qrw_pkg.sv
package qrw_pkg;
    // Opcodes handled by this block
    localparam logic [7:0] OP_QIO_DDR_READ = 8'hed;
    localparam logic [7:0] OP_QIO_SDR_READ = 8'heb;
    localparam logic [7:0] OP_WORD_READ = 8'he7;
    localparam logic [7:0] OP_SET_WRAP = 8'h77;
    localparam logic [7:0] OP_SET_PARAM = 8'hc0;
    localparam logic [7:0] OP_WRAP_READ = 8'h0c;
    localparam logic [7:0] OP_DDR_WRAP_READ = 8'h0e;
    localparam logic [7:0] OP_DDR_READ = 8'h0d;
    localparam logic [7:0] OP_SFDP_READ = 8'h5a;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
    // Training pattern, sent MSB first
    localparam logic [7:0] TRAIN_PATTERN = 8'h34;
    // Dummy clock counts
    localparam logic [3:0] DUMMY_DDR_SPI = 4'h7;
    localparam logic [3:0] DUMMY_WORD = 4'h2;
    localparam logic [3:0] DUMMY_SDR_SPI_DC0 = 4'h4;
    localparam logic [3:0] DUMMY_SDR_SPI_DC1 = 4'h6;
    localparam logic [3:0] DUMMY_P00 = 4'ha;
    localparam logic [3:0] DUMMY_P01 = 4'h4;
    localparam logic [3:0] DUMMY_P10 = 4'h6;
    localparam logic [3:0] DUMMY_P11 = 4'h8;
    localparam logic [3:0] DUMMY_DDR_QUAD = 4'h8;
    // Training pattern start offset within dummy phase (quad reads)
    localparam logic [3:0] TRAIN_START = 4'h4;
    // Reset values
    localparam logic WRAP_DISABLE_RST = 1'b1;
    localparam logic [1:0] WRAP_LEN_RST = 2'h0;
    localparam logic [1:0] DUMMY_SEL_RST = 2'h0;
    localparam logic [1:0] WRAP_SEL_RST = 2'h0;
    localparam int ADDR_W = 24;

    // Settings held across frames
    typedef struct packed {
        logic four_wire_command_mode;
        logic wrap_disable_bit;
        logic [1:0] wrap_length_bits;
        logic [1:0] dummy_select_field;
        logic [1:0] wrap_select_field;
    } qrw_cfg_t;

    // Per-frame phases
    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_ARG, PH_IGNORE
    } qrw_phase_t;

    // Read request toward the array
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } qrw_req_t;
endpackage

// >>> rtl/qrw_sync.sv
`timescale 1ns/100ps
// Three-stage level synchroniser; output changes once stages two and three agree
module qrw_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } qrw_sync_st_t;
    qrw_sync_st_t st_reg;
    qrw_sync_st_t st_next;

    // Stage one feeds only stage two
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
    end

    // Frozen while the enable is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else if (en) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;
endmodule // qrw_sync

// >>> verif/qrw_host.sv
`timescale 1ns/100ps
// Host controller model: owns the serial clock, select and I/O lines
module qrw_host (
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io
);
    logic quad; // Host view of four-wire command mode
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io = 4'h0;
        quad = 1'b0;
    end
    // One link clock, 30 ns; lines only change while it is low
    task automatic tick();
        #15 sclk = 1'b1;
        #15 sclk = 1'b0;
    endtask
    // Shift n units MSB first: nibbles on all lines, or bits on line 0
    task automatic shift(input logic [31:0] v, input int n, input logic q);
        for (int i = n - 1; i >= 0; i--) begin
            io = q ? v[4*i +: 4] : {3'h0, v[i]};
            tick();
        end
    endtask
    // End of frame: released lines flip so a stale value never looks valid
    task automatic stop();
        cs_n = 1'b1;
        io = ~io;
        tick(); // One edge with select high clears the frame phase
    endtask
endmodule // qrw_host

// >>> verif/test_quad_read_wrap_mode_control.sv
`timescale 1ns/100ps
// Self-checking bench for the quad read, wrap and mode commands
module test_quad_read_wrap_mode_control;
    logic clk, resetn, tpe, sclk, cs_n;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] array_addr;
    logic [7:0] array_data, read_params;
    logic four_wire_mode, wrap_active_cfg, reject_seen;
    int failures, checks;
    logic [3:0] edum [4] = '{4'ha, 4'h4, 4'h6, 4'h8}; // Four-wire EBh/0Ch dummies
    logic [3:0] ddum [4] = '{4'ha, 4'h8, 4'h8, 4'h8}; // Four-wire double-rate dummies
    // Array contents are a function of the address, so wrap errors show
    assign array_data = array_addr[7:0] ^ 8'ha5;
    qrw_host host_inst (.sclk(sclk), .cs_n(cs_n), .io(io_in));
    qrw_core qrw_core_inst (.CLK(clk), .RESETN(resetn), .CLK_EN(1'b1), .SCLK(sclk), .CS_N(cs_n),
        .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .DUMMY_CONFIG_BIT(1'b0),
        .TRAINING_PATTERN_ENABLE(tpe), .ARRAY_ADDR(array_addr), .ARRAY_DATA(array_data),
        .FOUR_WIRE_MODE(four_wire_mode), .WRAP_ACTIVE_CFG(wrap_active_cfg),
        .READ_PARAMS(read_params), .REJECT_SEEN(reject_seen));
    initial clk = 1'b0;
    always #2 clk = ~clk;
    // Value compare, case equality so unknowns fail
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Command frame with optional argument of n units
    task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int n);
        host_inst.cs_n = 1'b0;
        host_inst.shift({24'h0, op}, host_inst.quad ? 2 : 8, host_inst.quad);
        if (n > 0) host_inst.shift(arg, n, host_inst.quad);
        host_inst.stop();
        repeat (12) @(negedge clk); // Let the synced status settle
    endtask
    // Read frame; wl is the wrap length in bytes, 0 for a plain increment
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd, input int nb, input int wl);
        logic [23:0] e;
        logic [7:0] b;
        host_inst.cs_n = 1'b0;
        host_inst.shift({24'h0, op}, host_inst.quad ? 2 : 8, host_inst.quad);
        host_inst.shift({8'h0, a}, 6, 1'b1);
        for (int k = 1; k <= nd; k++) begin
            host_inst.io = (k <= 2) ? 4'h0 : ~host_inst.io;
            if (tpe && k > 4 && k < 13) compare(32'(io_out), 32'({4{qrw_pkg::TRAIN_PATTERN[12-k]}}));
            host_inst.tick();
        end
        for (int i = 0; i < nb; i++) begin
            e = (a & ~24'(wl - 1)) | ((a + 24'(i)) & 24'(wl - 1));
            b[7:4] = io_out;
            compare(32'(io_oe), 32'hf);
            host_inst.io = ~host_inst.io;
            host_inst.tick();
            b[3:0] = io_out;
            host_inst.io = ~host_inst.io;
            host_inst.tick();
            compare(32'(b), 32'(e[7:0] ^ 8'ha5));
        end
        host_inst.stop();
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog, well beyond the expected run of about 4500 system clock cycles
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        tpe = 1'b0;
        failures = 0;
        checks = 0;
        host_inst.tick(); // Link edge inside reset
        repeat (5) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        repeat (4) @(negedge clk);
        compare(32'({four_wire_mode, wrap_active_cfg, reject_seen}), 32'h0);
        $display("test reset done");
        rd(qrw_pkg::OP_QIO_DDR_READ, 24'h00003e, 8, 4, 0);
        cmd(qrw_pkg::OP_SET_PARAM, 32'h31, 8);
        compare(32'({reject_seen, read_params}), 32'h100);
        cmd(qrw_pkg::OP_SET_WRAP, 32'h0, 32);
        compare(32'(wrap_active_cfg), 32'h1);
        rd(qrw_pkg::OP_QIO_DDR_READ, 24'h000106, 8, 4, 8);
        rd(qrw_pkg::OP_WORD_READ, 24'h000206, 2, 3, 8);
        $display("test single-wire done");
        cmd(qrw_pkg::OP_ENTER_QUAD, 32'h0, 0);
        host_inst.quad = 1'b1;
        compare(32'({four_wire_mode, wrap_active_cfg}), 32'h3);
        cmd(qrw_pkg::OP_SET_PARAM, 32'h31, 2);
        compare(32'(read_params), 32'h31);
        rd(qrw_pkg::OP_QIO_DDR_READ, 24'h000306, 8, 3, 0);
        rd(qrw_pkg::OP_WRAP_READ, 24'h00040e, 8, 3, 16);
        rd(qrw_pkg::OP_DDR_WRAP_READ, 24'h00041e, 8, 3, 16);
        for (int p = 0; p < 4; p++) begin
            cmd(qrw_pkg::OP_SET_PARAM, 32'(p * 16 + 3), 2);
            rd(qrw_pkg::OP_QIO_SDR_READ, 24'h000510, edum[p], 2, 0);
            rd(qrw_pkg::OP_DDR_READ, 24'h00053f, ddum[p], 2, 0);
            rd(qrw_pkg::OP_WRAP_READ, 24'h00057e, edum[p], 3, 64);
        end
        cmd(qrw_pkg::OP_SET_PARAM, 32'h0, 2);
        @(negedge clk) tpe = 1'b1;
        rd(qrw_pkg::OP_WRAP_READ, 24'h000600, 10, 1, 8);
        @(negedge clk) tpe = 1'b0;
        $display("test four-wire done");
        cmd(qrw_pkg::OP_EXIT_QUAD, 32'h0, 0);
        host_inst.quad = 1'b0;
        compare(32'({four_wire_mode, wrap_active_cfg}), 32'h1);
        cmd(qrw_pkg::OP_SET_WRAP, 32'h10, 32);
        compare(32'(wrap_active_cfg), 32'h0);
        rd(qrw_pkg::OP_QIO_DDR_READ, 24'h0001fe, 8, 3, 0);
        $display("test exit done");
        stop_test();
    end
endmodule // test_quad_read_wrap_mode_control
